// ### core/msc_pkg.sv
// Purpose: shared constants for the sideband control block
// Assumes: 20 MHz system clock, APB slave with 32-bit data
// Notes:   offsets are byte addresses of aligned words
package msc_pkg;
	// register byte offsets
	localparam logic [7:0] MSC_CFG_OFS    = 8'h00;
	localparam logic [7:0] MSC_STATUS_OFS = 8'h04;
	localparam logic [7:0] MSC_CTRL_OFS   = 8'h08;
	localparam logic [7:0] MSC_TUNER_OFS  = 8'h0C;
	localparam logic [7:0] MSC_TXPWR_OFS  = 8'h10;
	localparam logic [7:0] MSC_EVENT_OFS  = 8'h14;
	// cfg field positions
	localparam int MSC_CFG_HOTPLUG  = 0;
	localparam int MSC_CFG_INVERT   = 1;
	localparam int MSC_CFG_WAKE     = 2;
	localparam int MSC_CFG_RFDIS_EN = 3;
	localparam int MSC_CFG_SERIAL   = 4;
	// ctrl field positions
	localparam int MSC_CTRL_RF_SW   = 0;
	localparam int MSC_CTRL_WAKE    = 1;
	// status field positions
	localparam int MSC_ST_CARD      = 0;
	localparam int MSC_ST_RF_ON     = 1;
	localparam int MSC_ST_BACKOFF   = 2;
	localparam int MSC_ST_WAKE      = 3;
	localparam int MSC_ST_RFDIS     = 4;
	// event field positions
	localparam int MSC_EV_INSERT    = 0;
	localparam int MSC_EV_REMOVE    = 1;
	// reset values: hot-plug on, rf-disable honoured, wake off
	localparam logic [4:0] MSC_CFG_RST  = 5'h09;
	localparam logic [1:0] MSC_CTRL_RST = 2'h1;
	localparam logic [7:0] MSC_TXPWR_DEF_RST = 8'hFF;
	localparam logic [7:0] MSC_TXPWR_THR_RST = 8'h80;
	// timing
	localparam int MSC_CLK_HZ       = 20_000_000;
	localparam int MSC_WAKE_MS      = 1000;
	localparam int MSC_WAKE_CYC     = MSC_CLK_HZ / 1000 * MSC_WAKE_MS;
	localparam int MSC_DEB_US       = 100;
	localparam int MSC_DEB_CYC      = MSC_CLK_HZ / 1_000_000 * MSC_DEB_US;
	// wake pulse states
	typedef enum logic [1:0] {
		MSC_WK_IDLE  = 2'b01,
		MSC_WK_PULSE = 2'b10
	} msc_wake_t;
endpackage

// ### core/msc_debounce.sv
// Purpose: synchroniser and debouncer for one asynchronous input
// Assumes: single clock domain, asynchronous active-high reset
// Notes:   output changes only after the input has been stable for DEB_CYC cycles
`timescale 1ns/1ns
`default_nettype none
module msc_debounce #(
	parameter int   DEB_CYC = 2000,
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_in,
	// level
	input  wire logic raw_in,
	output logic      level_out
);
	localparam int CW = $clog2(DEB_CYC + 1);
	logic          sync1_q;
	logic          sync2_q;
	logic [CW-1:0] cnt_q;
	logic          level_q;

	initial begin
		if (DEB_CYC < 1) $error("msc_debounce: DEB_CYC must be at least 1");
	end

	// two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_q <= RST_VAL;
			sync2_q <= RST_VAL;
		end else begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	// stability counter restarts whenever the input agrees with the output
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q   <= '0;
			level_q <= RST_VAL;
		end else if (sync2_q == level_q) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(DEB_CYC - 1)) begin
			cnt_q   <= '0;
			level_q <= sync2_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign level_out = level_q;
endmodule
`default_nettype wire

// ### core/msc_sideband.sv
// Purpose: sideband control of a modem card: card detect, led, host wake,
//          rf disable, body-proximity backoff and antenna tuner select
// Assumes: pins are asynchronous; apb master on the same 20 MHz clock
// Notes:   the rffe engine itself lives elsewhere; this block muxes its pins
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - with hot-plug on, debounced card-present level decides insert or remove
// - hot-plug detection enabled by setting 1, the reset default
// - hot-plug off: card level frozen at its value when hot-plug was switched off
// - card-present active high by default, invertible by configuration
// - open-drain led pulled low while rf on, released while rf off
// - wake request drives host wake low 1 s then high; idle high
// - host wake disabled after reset, enabled by setting 1
// - rf-disable low turns wireless off, flight mode
// - rf-disable high or floating turns wireless on
// - software command also switches rf on or off
// - rf-disable honoured by default, configuration may ignore it
// - power-reduce low limits transmit power to the threshold
// - power-reduce high keeps the default transmit power limit
// - the power threshold is programmable by software
// - tuner control in serial rffe mode or 4-bit parallel mode
// - parallel mode drives four pins, bit0 to bit3 of the word
// - serial mode drives rffe clock, rffe data is two-way
module msc_sideband
	import msc_pkg::*;
#(
	parameter int WAKE_CYC = MSC_WAKE_CYC,
	parameter int DEB_CYC  = MSC_DEB_CYC
) (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// sideband pins
	input  wire logic        card_present_in,
	input  wire logic        rf_disable_n_in,
	input  wire logic        power_reduce_n_in,
	output logic             status_led_n_out,
	output logic             status_led_n_oe_out,
	output logic             host_wake_n_out,
	// modem core side
	input  wire logic        wake_req_in,
	output logic             rf_on_out,
	output logic [7:0]       tx_power_limit_out,
	output logic             card_insert_out,
	output logic             card_remove_out,
	output logic             card_present_out,
	// rffe engine side
	input  wire logic        rffe_sclk_in,
	input  wire logic        rffe_sdata_in,
	input  wire logic        rffe_sdata_oe_in,
	output logic             rffe_sdata_rx_out,
	// tuner pins
	output logic             rffe_sclk_out,
	output logic             rffe_sdata_out,
	output logic             rffe_sdata_oe_out,
	input  wire logic        rffe_sdata_pin_in,
	output logic             tuner_ctl_bit0_out,
	output logic             tuner_ctl_bit1_out,
	output logic             tuner_ctl_bit2_out,
	output logic             tuner_ctl_bit3_out
);
	localparam int WCW = $clog2(WAKE_CYC + 1);

	initial begin
		if (WAKE_CYC < 1) $error("msc_sideband: WAKE_CYC must be at least 1");
		if (DEB_CYC < 1) $error("msc_sideband: DEB_CYC must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [4:0]     cfg_q;
	logic [1:0]     ctrl_q;
	logic [3:0]     tuner_q;
	logic [7:0]     txpwr_def_q;
	logic [7:0]     txpwr_thr_q;
	logic [1:0]     event_q;
	logic [31:0]    prdata_q;
	logic           wr_en;
	logic           rd_en;
	logic           wr_cfg;
	logic           wr_ctrl;
	logic           wr_tuner;
	logic           wr_txpwr;
	logic           wr_event;
	logic           addr_ok;
	logic           wake_sw;

	// sideband state
	logic           card_raw;
	logic           card_deb;
	logic           rfdis_deb;
	logic           prox_deb;
	logic           card_q;
	logic           card_start_q;
	logic           start_done_q;
	logic           rf_on;
	logic           backoff;
	msc_wake_t      wake_st_q;
	logic [WCW-1:0] wake_cnt_q;
	logic           wake_fire;

	////////////////////////////////////////////////////////////////////////
	// input conditioning
	assign card_raw = card_present_in ^ cfg_q[MSC_CFG_INVERT];

	msc_debounce #(.DEB_CYC(DEB_CYC), .RST_VAL(1'b0)) u_deb_card (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.raw_in     (card_raw),
		.level_out  (card_deb)
	);

	msc_debounce #(.DEB_CYC(DEB_CYC), .RST_VAL(1'b1)) u_deb_rfdis (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.raw_in     (rf_disable_n_in),
		.level_out  (rfdis_deb)
	);

	msc_debounce #(.DEB_CYC(DEB_CYC), .RST_VAL(1'b1)) u_deb_prox (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.raw_in     (power_reduce_n_in),
		.level_out  (prox_deb)
	);

	////////////////////////////////////////////////////////////////////////
	// apb decode: zero wait states, unmapped addresses answer slverr
	assign wr_en    = psel_in & penable_in & pwrite_in;
	assign rd_en    = psel_in & ~penable_in & ~pwrite_in; // setup edge: data stands in access
	assign wr_cfg   = wr_en & pstrb_in[0] & (paddr_in == MSC_CFG_OFS);
	assign wr_ctrl  = wr_en & pstrb_in[0] & (paddr_in == MSC_CTRL_OFS);
	assign wr_tuner = wr_en & pstrb_in[0] & (paddr_in == MSC_TUNER_OFS);
	assign wr_txpwr = wr_en & (paddr_in == MSC_TXPWR_OFS);
	assign wr_event = wr_en & pstrb_in[0] & (paddr_in == MSC_EVENT_OFS);
	assign wake_sw  = wr_ctrl & pwdata_in[MSC_CTRL_WAKE];

	always_comb begin
		if (paddr_in == MSC_CFG_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr_in == MSC_STATUS_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr_in == MSC_CTRL_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr_in == MSC_TUNER_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr_in == MSC_TXPWR_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr_in == MSC_EVENT_OFS) begin
			addr_ok = 1'b1;
		end else begin
			addr_ok = 1'b0;
		end
	end

	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~addr_ok;
	assign prdata_out  = prdata_q;

	// configuration; hot-plug and rf-disable honouring on, wake off at reset
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q <= MSC_CFG_RST;
		end else if (wr_cfg) begin
			cfg_q <= pwdata_in[4:0];
		end
	end

	// software rf switch; the wake bit is a self-clearing strobe
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q <= MSC_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= {1'b0, pwdata_in[MSC_CTRL_RF_SW]};
		end
	end

	// tuner word
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tuner_q <= '0;
		end else if (wr_tuner) begin
			tuner_q <= pwdata_in[3:0];
		end
	end

	// default limit in byte 0, threshold in byte 1
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			txpwr_def_q <= MSC_TXPWR_DEF_RST;
			txpwr_thr_q <= MSC_TXPWR_THR_RST;
		end else if (wr_txpwr) begin
			if (pstrb_in[0]) begin
				txpwr_def_q <= pwdata_in[7:0];
			end
			if (pstrb_in[1]) begin
				txpwr_thr_q <= pwdata_in[15:8];
			end
		end
	end

	// read data registered at the setup edge, so it stands through the access phase
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_q <= '0;
		end else if (rd_en) begin
			if (paddr_in == MSC_CFG_OFS) begin
				prdata_q <= {27'h0, cfg_q};
			end else if (paddr_in == MSC_STATUS_OFS) begin
				prdata_q <= {27'h0, ~rfdis_deb, wake_st_q == MSC_WK_PULSE,
					backoff, rf_on, card_q};
			end else if (paddr_in == MSC_CTRL_OFS) begin
				prdata_q <= {31'h0, ctrl_q[MSC_CTRL_RF_SW]};
			end else if (paddr_in == MSC_TUNER_OFS) begin
				prdata_q <= {28'h0, tuner_q};
			end else if (paddr_in == MSC_TXPWR_OFS) begin
				prdata_q <= {16'h0, txpwr_thr_q, txpwr_def_q};
			end else if (paddr_in == MSC_EVENT_OFS) begin
				prdata_q <= {30'h0, event_q};
			end else begin
				prdata_q <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// card detection; start-up sample taken on the first cycle after reset
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			card_start_q <= 1'b0;
			start_done_q <= 1'b0;
		end else if (!start_done_q) begin
			card_start_q <= card_deb;
			start_done_q <= 1'b1;
		end
	end

	// tracked card level; frozen while hot-plug is off
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			card_q <= 1'b0;
		end else if (!start_done_q) begin
			card_q <= card_deb;
		end else if (cfg_q[MSC_CFG_HOTPLUG]) begin
			card_q <= card_deb;
		end
	end

	// one-cycle event pulses from level changes
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			card_insert_out <= 1'b0;
			card_remove_out <= 1'b0;
		end else begin
			card_insert_out <= start_done_q & cfg_q[MSC_CFG_HOTPLUG] & card_deb & ~card_q;
			card_remove_out <= start_done_q & cfg_q[MSC_CFG_HOTPLUG] & ~card_deb & card_q;
		end
	end

	// sticky event flags; write one to clear, a new event wins over clear
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			event_q <= '0;
		end else begin
			event_q[MSC_EV_INSERT] <= card_insert_out |
				(event_q[MSC_EV_INSERT] & ~(wr_event & pwdata_in[MSC_EV_INSERT]));
			event_q[MSC_EV_REMOVE] <= card_remove_out |
				(event_q[MSC_EV_REMOVE] & ~(wr_event & pwdata_in[MSC_EV_REMOVE]));
		end
	end

	assign card_present_out = card_q;

	////////////////////////////////////////////////////////////////////////
	// rf state: software switch and, unless ignored, the hardware pin
	assign rf_on = ctrl_q[MSC_CTRL_RF_SW] &
		(rfdis_deb | ~cfg_q[MSC_CFG_RFDIS_EN]);

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rf_on_out <= 1'b0;
		end else begin
			rf_on_out <= rf_on;
		end
	end

	// open-drain led: drive low only while rf is on, else release
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			status_led_n_oe_out <= 1'b0;
		end else begin
			status_led_n_oe_out <= rf_on;
		end
	end
	assign status_led_n_out = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// body-proximity backoff picks the transmit ceiling
	assign backoff = ~prox_deb;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_power_limit_out <= MSC_TXPWR_DEF_RST;
		end else if (backoff) begin
			tx_power_limit_out <= txpwr_thr_q;
		end else begin
			tx_power_limit_out <= txpwr_def_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host wake pulse; a request during a pulse does not stretch it
	assign wake_fire = cfg_q[MSC_CFG_WAKE] & (wake_req_in | wake_sw);

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wake_st_q  <= MSC_WK_IDLE;
			wake_cnt_q <= '0;
		end else begin
			case (wake_st_q)
				MSC_WK_IDLE: begin
					if (wake_fire) begin
						wake_st_q  <= MSC_WK_PULSE;
						wake_cnt_q <= WCW'(WAKE_CYC - 1);
					end
				end
				MSC_WK_PULSE: begin
					if (wake_cnt_q == '0) begin
						wake_st_q <= MSC_WK_IDLE;
					end else begin
						wake_cnt_q <= wake_cnt_q - 1'b1;
					end
				end
				default: begin
					wake_st_q <= MSC_WK_IDLE;
				end
			endcase
		end
	end

	// low for exactly WAKE_CYC cycles, high otherwise
	assign host_wake_n_out = (wake_st_q != MSC_WK_PULSE);

	////////////////////////////////////////////////////////////////////////
	// tuner pin mux; unused mode's pins held low and data released
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tuner_ctl_bit0_out <= 1'b0;
			tuner_ctl_bit1_out <= 1'b0;
			tuner_ctl_bit2_out <= 1'b0;
			tuner_ctl_bit3_out <= 1'b0;
		end else begin
			tuner_ctl_bit0_out <= ~cfg_q[MSC_CFG_SERIAL] & tuner_q[0];
			tuner_ctl_bit1_out <= ~cfg_q[MSC_CFG_SERIAL] & tuner_q[1];
			tuner_ctl_bit2_out <= ~cfg_q[MSC_CFG_SERIAL] & tuner_q[2];
			tuner_ctl_bit3_out <= ~cfg_q[MSC_CFG_SERIAL] & tuner_q[3];
		end
	end

	// serial mode passes the engine's clock and data through
	assign rffe_sclk_out     = cfg_q[MSC_CFG_SERIAL] & rffe_sclk_in;
	assign rffe_sdata_out    = rffe_sdata_in;
	assign rffe_sdata_oe_out = cfg_q[MSC_CFG_SERIAL] & rffe_sdata_oe_in;
	assign rffe_sdata_rx_out = rffe_sdata_pin_in;
endmodule
`default_nettype wire

// ### test/msc_sideband_chk.sv
// Purpose: port-level assertions for the sideband control block
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   wake pulse width is measured by a small counter
`timescale 1ns/1ns
`default_nettype none
module msc_sideband_chk #(
	parameter int WAKE_CYC = 50
) (
	// watched ports
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] prdata_out,
	input  wire logic        pslverr_out,
	input  wire logic        status_led_n_out,
	input  wire logic        status_led_n_oe_out,
	input  wire logic        host_wake_n_out,
	input  wire logic        wake_req_in,
	input  wire logic        rf_on_out,
	input  wire logic        card_insert_out,
	input  wire logic        card_remove_out,
	input  wire logic        rffe_sdata_pin_in,
	input  wire logic        rffe_sdata_rx_out
);
	logic [31:0] low_q;
	logic        ctrl_wr;
	////////////////////////////////////////
	// low-time counter, cleared on release so each pulse stands alone
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) low_q <= '0;
		else if (!host_wake_n_out) low_q <= low_q + 32'h1;
		else low_q <= '0;
	end
	// software wake strobe goes through the control word
	assign ctrl_wr = psel_in && penable_in && pwrite_in && paddr_in == 8'h08;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////
	chk_wake_width: assert property ($rose(host_wake_n_out) |-> low_q == WAKE_CYC)
		else $error("host wake low time wrong");
	chk_wake_cause: assert property ($fell(host_wake_n_out) |->
		$past(wake_req_in) || $past(ctrl_wr) || $past(ctrl_wr, 2))
		else $error("host wake fell with no request");
	chk_led_drain: assert property (status_led_n_out == 1'b0)
		else $error("led pin data not low");
	chk_led_rf_on: assert property (status_led_n_oe_out == rf_on_out)
		else $error("led enable differs from rf state");
	chk_event_pulse: assert property ((card_insert_out || card_remove_out) |=>
		!card_insert_out && !card_remove_out)
		else $error("card event longer than one cycle");
	chk_rffe_rx: assert property (rffe_sdata_rx_out == rffe_sdata_pin_in)
		else $error("rffe data not passed back");
	chk_unmapped_err: assert property (psel_in && penable_in && paddr_in > 8'h14 |-> pslverr_out)
		else $error("unmapped access without error");
	chk_mapped_ok: assert property (psel_in && penable_in && paddr_in <= 8'h14
		&& paddr_in[1:0] == 2'b00 |-> !pslverr_out)
		else $error("mapped access flagged");
	chk_rdata_hold: assert property (!$past(psel_in && !penable_in && !pwrite_in)
		|-> $stable(prdata_out))
		else $error("read data moved without a read");
endmodule
bind msc_sideband msc_sideband_chk #(.WAKE_CYC(WAKE_CYC)) i_msc_sideband_chk (
	.sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
	.pslverr_out, .status_led_n_out, .status_led_n_oe_out, .host_wake_n_out, .wake_req_in,
	.rf_on_out, .card_insert_out, .card_remove_out, .rffe_sdata_pin_in, .rffe_sdata_rx_out
);
`default_nettype wire

// ### test/msc_far_side.sv
// Purpose: card slot, flight switch, proximity sensor and tuner data pin
// Assumes: the bench commands each party by a level
// Notes:   pure wiring, the parties hold no state
`timescale 1ns/1ns
`default_nettype none
module msc_far_side (
	// commands from the bench
	input  wire logic card_in_slot_in,
	input  wire logic flight_sw_in,
	input  wire logic body_near_in,
	// tuner data from the block
	input  wire logic sdata_drv_in,
	input  wire logic sdata_oe_in,
	// pins toward the block
	output logic      card_present_out,
	output logic      rf_disable_n_out,
	output logic      power_reduce_n_out,
	output logic      sdata_pin_out
);
	// normally-open slot: an inserted card pulls detect high
	assign card_present_out = card_in_slot_in;
	// switch grounds the line, pull-up otherwise
	assign rf_disable_n_out = !flight_sw_in;
	// sensor pulls low only while a body is near
	assign power_reduce_n_out = !body_near_in;
	// released data line sits at its pull-down level
	assign sdata_pin_out = sdata_oe_in ? sdata_drv_in : 1'b0;
endmodule
`default_nettype wire

// ### test/test_msc_sideband.sv
// Purpose: register-driven scenarios for the sideband control block
// Assumes: short debounce and wake counts through parameters
// Notes:   read data is taken at the edge that samples pready high
`timescale 1ns/1ns
`default_nettype none
module test_msc_sideband;
	import msc_pkg::*;
	localparam int DEB = 4;
	localparam int WK  = 50;
	localparam int S   = DEB + 8;
	logic        sys_clk_in, rst_in, psel_in, penable_in, pwrite_in;
	logic [7:0]  paddr_in, tx_power_limit_out;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic [3:0]  pstrb_in;
	logic        pready_out, pslverr_out, err, card_set, flight, body;
	logic        card_present_in, rf_disable_n_in, power_reduce_n_in;
	logic        status_led_n_out, status_led_n_oe_out, host_wake_n_out, wake_req_in;
	logic        rf_on_out, card_insert_out, card_remove_out, card_present_out;
	logic        rffe_sclk_in, rffe_sdata_in, rffe_sdata_oe_in, rffe_sdata_rx_out;
	logic        rffe_sclk_out, rffe_sdata_out, rffe_sdata_oe_out, rffe_sdata_pin_in;
	logic        tuner_ctl_bit0_out, tuner_ctl_bit1_out, tuner_ctl_bit2_out;
	logic        tuner_ctl_bit3_out;
	int          n_mismatch, cmp_count;
	////////////////////////////////////////
	msc_sideband #(.WAKE_CYC(WK), .DEB_CYC(DEB)) i_msc_sideband (
		.sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
		.pstrb_in, .prdata_out, .pready_out, .pslverr_out, .card_present_in,
		.rf_disable_n_in, .power_reduce_n_in, .status_led_n_out, .status_led_n_oe_out,
		.host_wake_n_out, .wake_req_in, .rf_on_out, .tx_power_limit_out, .card_insert_out,
		.card_remove_out, .card_present_out, .rffe_sclk_in, .rffe_sdata_in,
		.rffe_sdata_oe_in, .rffe_sdata_rx_out, .rffe_sclk_out, .rffe_sdata_out,
		.rffe_sdata_oe_out, .rffe_sdata_pin_in, .tuner_ctl_bit0_out, .tuner_ctl_bit1_out,
		.tuner_ctl_bit2_out, .tuner_ctl_bit3_out);
	msc_far_side i_msc_far_side (
		.card_in_slot_in(card_set), .flight_sw_in(flight), .body_near_in(body),
		.sdata_drv_in(rffe_sdata_out), .sdata_oe_in(rffe_sdata_oe_out),
		.card_present_out(card_present_in), .rf_disable_n_out(rf_disable_n_in),
		.power_reduce_n_out(power_reduce_n_in), .sdata_pin_out(rffe_sdata_pin_in));
	////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// one apb transfer; the request holds until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		err = pslverr_out;
		rd = prdata_out;
		if (n >= 20) begin
			n_mismatch++;
			conclude();
		end
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic rdx(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// waits, then lets the edge's updates land before looking
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	////////////////////////////////////////
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	// main sequence
	initial begin
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
		{card_set, flight, body, wake_req_in, rffe_sclk_in} = '0;
		{rffe_sdata_in, rffe_sdata_oe_in, n_mismatch, cmp_count} = '0;
		pstrb_in = 4'hF;
		rst_in = 1'b1;
		repeat (10) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rdx(MSC_CFG_OFS, 32'h9);
		rdx(MSC_CTRL_OFS, 32'h1);
		rdx(MSC_TXPWR_OFS, 32'h80FF);
		rdx(MSC_STATUS_OFS, 32'h2);
		chk(host_wake_n_out, 1'b1);
		rdx(8'h18, 32'h0);
		chk(err, 1'b1);
		$display("test reset done");
		@(posedge sys_clk_in) card_set <= 1'b1;
		tick(S);
		chk(card_present_out, 1'b1);
		rdx(MSC_EVENT_OFS, 32'h1);
		apb(1'b1, MSC_EVENT_OFS, 32'h3);
		@(posedge sys_clk_in) card_set <= 1'b0;
		tick(DEB - 2);
		@(posedge sys_clk_in) card_set <= 1'b1;
		tick(S);
		rdx(MSC_EVENT_OFS, 32'h0);
		@(posedge sys_clk_in) card_set <= 1'b0;
		tick(S);
		chk(card_present_out, 1'b0);
		rdx(MSC_EVENT_OFS, 32'h2);
		apb(1'b1, MSC_CFG_OFS, 32'hB);
		tick(S);
		chk(card_present_out, 1'b1);
		apb(1'b1, MSC_CFG_OFS, 32'h9);
		tick(S);
		apb(1'b1, MSC_CFG_OFS, 32'h8);
		apb(1'b1, MSC_EVENT_OFS, 32'h3);
		@(posedge sys_clk_in) card_set <= 1'b1;
		tick(S);
		chk(card_present_out, 1'b0);
		rdx(MSC_EVENT_OFS, 32'h0);
		$display("test card done");
		@(posedge sys_clk_in) flight <= 1'b1;
		tick(S);
		chk(rf_on_out, 1'b0);
		chk(status_led_n_oe_out, 1'b0);
		apb(1'b1, MSC_CFG_OFS, 32'h1);
		tick(3);
		chk(rf_on_out, 1'b1);
		apb(1'b1, MSC_CFG_OFS, 32'h9);
		@(posedge sys_clk_in) flight <= 1'b0;
		tick(S);
		chk(status_led_n_oe_out, 1'b1);
		apb(1'b1, MSC_CTRL_OFS, 32'h0);
		tick(3);
		chk(rf_on_out, 1'b0);
		apb(1'b1, MSC_CTRL_OFS, 32'h1);
		$display("test rf done");
		@(posedge sys_clk_in) body <= 1'b1;
		tick(S);
		chk(tx_power_limit_out, 8'h80);
		apb(1'b1, MSC_TXPWR_OFS, 32'h3370);
		tick(3);
		chk(tx_power_limit_out, 8'h33);
		@(posedge sys_clk_in) body <= 1'b0;
		tick(S);
		chk(tx_power_limit_out, 8'h70);
		$display("test power done");
		@(posedge sys_clk_in) wake_req_in <= 1'b1;
		@(posedge sys_clk_in) wake_req_in <= 1'b0;
		tick(4);
		chk(host_wake_n_out, 1'b1);
		apb(1'b1, MSC_CFG_OFS, 32'hD);
		@(posedge sys_clk_in) wake_req_in <= 1'b1;
		@(posedge sys_clk_in) wake_req_in <= 1'b0;
		tick(2);
		chk(host_wake_n_out, 1'b0);
		tick(WK);
		chk(host_wake_n_out, 1'b1);
		apb(1'b1, MSC_CTRL_OFS, 32'h3);
		tick(1);
		chk(host_wake_n_out, 1'b0);
		tick(WK + 2);
		chk(host_wake_n_out, 1'b1);
		$display("test wake done");
		apb(1'b1, MSC_TUNER_OFS, 32'hA);
		tick(3);
		chk({tuner_ctl_bit3_out, tuner_ctl_bit2_out, tuner_ctl_bit1_out,
			tuner_ctl_bit0_out}, 4'hA);
		@(posedge sys_clk_in) {rffe_sclk_in, rffe_sdata_in, rffe_sdata_oe_in} <= 3'h7;
		tick(1);
		chk({rffe_sclk_out, rffe_sdata_oe_out}, 2'h0);
		apb(1'b1, MSC_CFG_OFS, 32'h19);
		tick(3);
		chk({tuner_ctl_bit3_out, tuner_ctl_bit2_out}, 2'h0);
		chk({rffe_sclk_out, rffe_sdata_oe_out, rffe_sdata_rx_out}, 3'h7);
		chk(rffe_sdata_out, 1'b1);
		$display("test tuner done");
		conclude();
	end
endmodule
`default_nettype wire
